// *** hdl/sfu_pkg.sv ***
// shared constants and types for the serial firmware update sequencer
package sfu_pkg;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_COMMA = 8'h2c;
  // keywords as the last four received characters, right aligned
  localparam logic [31:0] KW_ENTER = 32'h00444655;
  localparam logic [31:0] KW_REQUEST = 32'h44465555;
  localparam logic [31:0] KW_START = 32'h44465553;
  localparam logic [31:0] KW_FRAGMENT = 32'h44465544;
  localparam logic [31:0] KW_COMPLETE = 32'h44465543;
  localparam logic [31:0] KW_TERMINATE = 32'h44465545;
  localparam logic [15:0] MAX_FRAG_LEN = 16'h0200;
  localparam logic [3:0] SIZE_ALIGN_MASK = 4'hf;
  localparam logic [15:0] CHECK_POLY = 16'h1021;
  localparam logic [15:0] CHECK_INIT = 16'hffff;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DIST_TIMEOUT_MS = 100;
  localparam int DIST_TIMEOUT_CYC = (DIST_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_CMD = 2'b00,
    MODE_UPD = 2'b01,
    MODE_DATA = 2'b10
  } sfu_mode_t;

  typedef enum logic [1:0] {
    PARSE_KEY = 2'b00,
    PARSE_HEX = 2'b01,
    PARSE_RAW = 2'b10,
    PARSE_TAIL = 2'b11
  } sfu_parse_t;

  typedef enum logic [3:0] {
    REP_END = 4'h0,
    REP_PROMPT = 4'h1,
    REP_ECHO = 4'h2,
    REP_ACK = 4'h3,
    REP_ERR = 4'h4,
    REP_BUSY = 4'h5,
    REP_VALIDATING = 4'h6,
    REP_VAL_OK = 4'h7,
    REP_VAL_FAIL = 4'h8,
    REP_REBOOT = 4'h9
  } sfu_code_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sfu_byte_t;

  typedef struct packed {
    logic valid;
    sfu_code_t code;
    logic [15:0] value;
  } sfu_reply_t;
endpackage

// *** hdl/sfu_sequencer.sv ***
// command sequencer for firmware update over the serial command stream
module sfu_sequencer
  import sfu_pkg::*;
#(parameter int TIMEOUT_CYC = DIST_TIMEOUT_CYC) (
  input wire logic mclk,
  input wire logic rst,
  input wire sfu_byte_t rx,
  input wire logic busy,
  output sfu_reply_t reply,
  output sfu_mode_t mode,
  output logic reboot
);
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b0, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) return {1'b0, c[3:0] + 4'h9};
    return 5'h10;
  endfunction
  function automatic logic [15:0] check_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) x = x[15] ? ({x[14:0], 1'b0} ^ CHECK_POLY) : {x[14:0], 1'b0};
    return x;
  endfunction
  sfu_reply_t reply_r, reply_nxt;
  sfu_mode_t mode_r, mode_nxt;
  sfu_parse_t pst_r, pst_nxt;
  sfu_code_t pend_code_r, pend_code_nxt;
  logic pend_r, pend_nxt, reboot_r, reboot_nxt, bad_r, bad_nxt, frag_ok_r, frag_ok_nxt;
  logic [31:0] kw_r, kw_nxt, acc_r, acc_nxt, size_r, size_nxt, rcvd_r, rcvd_nxt, tmo_r, tmo_nxt;
  logic [31:0] fld_r [0:3], fld_nxt [0:3], f [0:3];
  logic [2:0] nf_r, nf_nxt, nf;
  logic [15:0] flen_r, flen_nxt, cnt_r, cnt_nxt;
  logic [15:0] ftmp_r, ftmp_nxt, chk_r, chk_nxt, chk_exp_r, chk_exp_nxt;
  logic req_ok_r, req_ok_nxt, started_r, started_nxt, dist_r, dist_nxt;
  logic done_r, done_nxt, val_ok_r, val_ok_nxt, exec, locked;
  logic [4:0] hv;
  assign reply = reply_r;
  assign mode = mode_r;
  assign reboot = reboot_r;
  always_comb begin
    reply_nxt = reply_r;
    reply_nxt.valid = 1'b0;
    mode_nxt = mode_r;
    pst_nxt = pst_r;
    pend_nxt = 1'b0;
    pend_code_nxt = pend_code_r;
    reboot_nxt = 1'b0;
    kw_nxt = kw_r;
    acc_nxt = acc_r;
    fld_nxt = fld_r;
    nf_nxt = nf_r;
    bad_nxt = bad_r;
    frag_ok_nxt = frag_ok_r;
    flen_nxt = flen_r;
    cnt_nxt = cnt_r;
    ftmp_nxt = ftmp_r;
    chk_nxt = chk_r;
    chk_exp_nxt = chk_exp_r;
    size_nxt = size_r;
    rcvd_nxt = rcvd_r;
    req_ok_nxt = req_ok_r;
    started_nxt = started_r;
    dist_nxt = dist_r;
    done_nxt = done_r;
    val_ok_nxt = val_ok_r;
    locked = dist_r && (rcvd_r != size_r);
    hv = hex_val(rx.data);
    f = fld_r;
    f[nf_r[1:0]] = acc_r;
    nf = (pst_r == PARSE_HEX) ? nf_r + 3'd1 : nf_r;
    exec = rx.valid && (pst_r != PARSE_RAW) && (rx.data == CHAR_CR) && (kw_r != 32'h0) &&
           (mode_r != MODE_DATA);
    tmo_nxt = (locked && !rx.valid) ? tmo_r + 32'd1 : 32'd0;
    if (pend_r) reply_nxt = '{valid: 1'b1, code: pend_code_r, value: 16'h0000};
    if (rx.valid && pst_r == PARSE_RAW) begin
      ftmp_nxt = check_byte(ftmp_r, rx.data);
      cnt_nxt = cnt_r - 16'd1;
      if (cnt_r == 16'd1) pst_nxt = PARSE_TAIL;
    end else if (rx.valid && rx.data == CHAR_CR) begin
      pst_nxt = PARSE_KEY;
      kw_nxt = 32'h0;
      acc_nxt = 32'h0;
      nf_nxt = 3'd0;
      bad_nxt = 1'b0;
    end else if (rx.valid && pst_r == PARSE_KEY) begin
      if (rx.data == CHAR_COMMA) pst_nxt = PARSE_HEX;
      else kw_nxt = {kw_r[23:0], rx.data};
    end else if (rx.valid && pst_r == PARSE_HEX) begin
      if (rx.data == CHAR_COMMA) begin
        if (nf_r[2]) bad_nxt = 1'b1;
        else fld_nxt[nf_r[1:0]] = acc_r;
        nf_nxt = nf_r + 3'd1;
        acc_nxt = 32'h0;
        if (kw_r == KW_FRAGMENT && nf_r == 3'd0) begin
          flen_nxt = acc_r[15:0];
          cnt_nxt = acc_r[15:0];
          ftmp_nxt = chk_r;
          frag_ok_nxt = started_r && !bad_r && acc_r[31:16] == 16'h0 &&
                        acc_r[15:0] != 16'h0 && acc_r[15:0] <= MAX_FRAG_LEN &&
                        rcvd_r + {16'h0, acc_r[15:0]} <= size_r;
          pst_nxt = (acc_r[15:0] == 16'h0) ? PARSE_TAIL : PARSE_RAW;
        end
      end else begin
        if (hv[4]) bad_nxt = 1'b1;
        else acc_nxt = {acc_r[27:0], hv[3:0]};
      end
    end else if (rx.valid && pst_r == PARSE_TAIL) begin
      bad_nxt = 1'b1;
    end
    if (exec) begin
      reply_nxt = '{valid: 1'b1, code: REP_ERR, value: 16'h0000};
      if (kw_r == KW_ENTER) begin
        if (mode_r == MODE_CMD) begin
          reply_nxt.code = REP_END;
          pend_nxt = 1'b1;
          pend_code_nxt = REP_PROMPT;
          mode_nxt = MODE_UPD;
        end
      end else if (mode_r != MODE_UPD || (locked && kw_r != KW_FRAGMENT)) begin
        reply_nxt.code = REP_ERR;
      end else if (kw_r == KW_REQUEST) begin
        if (nf == 3'd4 && !bad_r && (f[0][3:0] & SIZE_ALIGN_MASK) == 4'h0 && f[0] != 32'h0 &&
            f[1][31:8] == 24'h0 && f[3][31:16] == 16'h0) begin
          reply_nxt.code = REP_ECHO;
          reply_nxt.value = MAX_FRAG_LEN;
          req_ok_nxt = 1'b1;
          size_nxt = f[0];
          chk_exp_nxt = f[3][15:0];
          chk_nxt = CHECK_INIT;
          rcvd_nxt = 32'h0;
          started_nxt = 1'b0;
          dist_nxt = 1'b0;
          done_nxt = 1'b0;
          val_ok_nxt = 1'b0;
        end
      end else if (kw_r == KW_START) begin
        if (!req_ok_r) reply_nxt.code = REP_ERR;
        else if (busy) reply_nxt.code = REP_BUSY;
        else begin
          reply_nxt.code = REP_ACK;
          started_nxt = 1'b1;
        end
      end else if (kw_r == KW_FRAGMENT) begin
        if (frag_ok_r && pst_r == PARSE_TAIL && !bad_r && nf_r == 3'd1) begin
          reply_nxt.code = REP_ACK;
          dist_nxt = 1'b1;
          rcvd_nxt = rcvd_r + {16'h0, flen_r};
          chk_nxt = ftmp_r;
        end
      end else if (kw_r == KW_COMPLETE) begin
        if (dist_r && rcvd_r == size_r) begin
          reply_nxt.code = REP_VALIDATING;
          pend_nxt = 1'b1;
          pend_code_nxt = (chk_r == chk_exp_r) ? REP_VAL_OK : REP_VAL_FAIL;
          done_nxt = 1'b1;
          val_ok_nxt = (chk_r == chk_exp_r);
        end
      end else if (kw_r == KW_TERMINATE) begin
        reply_nxt.code = REP_END;
        req_ok_nxt = 1'b0;
        started_nxt = 1'b0;
        dist_nxt = 1'b0;
        done_nxt = 1'b0;
        val_ok_nxt = 1'b0;
        rcvd_nxt = 32'h0;
        if (done_r && val_ok_r) begin
          reply_nxt.code = REP_REBOOT;
          reboot_nxt = 1'b1;
          mode_nxt = MODE_DATA;
        end
      end
    end
    if (locked && tmo_r == TIMEOUT_CYC - 1 && !rx.valid) begin
      mode_nxt = MODE_CMD;
      pst_nxt = PARSE_KEY;
      kw_nxt = 32'h0;
      nf_nxt = 3'd0;
      req_ok_nxt = 1'b0;
      started_nxt = 1'b0;
      dist_nxt = 1'b0;
      done_nxt = 1'b0;
      rcvd_nxt = 32'h0;
      tmo_nxt = 32'd0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      reply_r <= '0;
      mode_r <= MODE_CMD;
      pst_r <= PARSE_KEY;
      pend_r <= 1'b0;
      pend_code_r <= REP_END;
      reboot_r <= 1'b0;
      kw_r <= 32'h0;
      acc_r <= 32'h0;
      fld_r <= '{default: 32'h0};
      nf_r <= 3'd0;
      bad_r <= 1'b0;
      frag_ok_r <= 1'b0;
      flen_r <= 16'h0;
      cnt_r <= 16'h0;
      ftmp_r <= 16'h0;
      chk_r <= CHECK_INIT;
      chk_exp_r <= 16'h0;
      size_r <= 32'h0;
      rcvd_r <= 32'h0;
      tmo_r <= 32'h0;
      req_ok_r <= 1'b0;
      started_r <= 1'b0;
      dist_r <= 1'b0;
      done_r <= 1'b0;
      val_ok_r <= 1'b0;
    end else begin
      reply_r <= reply_nxt;
      mode_r <= mode_nxt;
      pst_r <= pst_nxt;
      pend_r <= pend_nxt;
      pend_code_r <= pend_code_nxt;
      reboot_r <= reboot_nxt;
      kw_r <= kw_nxt;
      acc_r <= acc_nxt;
      fld_r <= fld_nxt;
      nf_r <= nf_nxt;
      bad_r <= bad_nxt;
      frag_ok_r <= frag_ok_nxt;
      flen_r <= flen_nxt;
      cnt_r <= cnt_nxt;
      ftmp_r <= ftmp_nxt;
      chk_r <= chk_nxt;
      chk_exp_r <= chk_exp_nxt;
      size_r <= size_nxt;
      rcvd_r <= rcvd_nxt;
      tmo_r <= tmo_nxt;
      req_ok_r <= req_ok_nxt;
      started_r <= started_nxt;
      dist_r <= dist_nxt;
      done_r <= done_nxt;
      val_ok_r <= val_ok_nxt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_PROMPT_AFTER_END: assert property (
    exec && kw_r == KW_ENTER && mode_r == MODE_CMD |=> reply_r.code == REP_END &&
    mode_r == MODE_UPD ##1 reply_r.valid && reply_r.code == REP_PROMPT)
    else $error("enter did not give end then prompt");
  AST_ECHO_MAX: assert property (
    reply_r.valid && reply_r.code == REP_ECHO |-> reply_r.value == MAX_FRAG_LEN)
    else $error("echo without maximum fragment size");
  AST_START_NO_REQ: assert property (
    exec && kw_r == KW_START && mode_r == MODE_UPD && !locked && !req_ok_r
    |=> reply_r.valid && reply_r.code == REP_ERR)
    else $error("start without request not refused");
  AST_LOCKED_REJECT: assert property (
    exec && locked && kw_r != KW_FRAGMENT |=> reply_r.code == REP_ERR && $stable(rcvd_r))
    else $error("command accepted during distribution");
  AST_FRAG_COUNT: assert property (
    exec && kw_r == KW_FRAGMENT ##1 reply_r.code == REP_ACK
    |-> rcvd_r == $past(rcvd_r) + {16'h0, $past(flen_r)} && rcvd_r <= size_r)
    else $error("fragment ack with wrong byte total");
  AST_TIMEOUT: assert property (
    locked && tmo_r == TIMEOUT_CYC - 1 && !rx.valid |=> mode_r == MODE_CMD && !dist_r)
    else $error("distribution timeout ignored");
  AST_VALIDATION_RESULT: assert property (
    reply_r.valid && reply_r.code == REP_VALIDATING
    |=> reply_r.valid && (reply_r.code == REP_VAL_OK || reply_r.code == REP_VAL_FAIL))
    else $error("validating without result event");
  AST_COMPLETE_SHORT: assert property (
    exec && kw_r == KW_COMPLETE && rcvd_r != size_r |=> reply_r.code == REP_ERR)
    else $error("complete accepted with short image");
  AST_REBOOT_DATA: assert property (
    reboot_r |-> mode_r == MODE_DATA && reply_r.valid && reply_r.code == REP_REBOOT)
    else $error("reboot without data mode");
  AST_TERM_ABORT: assert property (
    exec && kw_r == KW_TERMINATE && mode_r == MODE_UPD && !locked && !(done_r && val_ok_r)
    |=> reply_r.code == REP_END && mode_r == MODE_UPD && !started_r)
    else $error("terminate did not abort in update mode");
  AST_REPLY_CAUSE: assert property (
    reply_r.valid && !$past(pend_r) |-> $past(rx.valid) && $past(rx.data) == CHAR_CR)
    else $error("reply without a line terminator");
endmodule

// *** verif/sfu_host_model.sv ***
// host side model driving the command byte stream
module sfu_host_model
  import sfu_pkg::*;
(
  output sfu_byte_t rx,
  input wire logic mclk
);
  timeunit 1ns;
  timeprecision 100ps;

  initial rx = '0;

  function automatic logic [7:0] img_byte(int i);
    return 8'(i * 7 + 3);
  endfunction

  task automatic put(logic [7:0] b);
    rx.valid = 1'b1;
    rx.data = b;
    @(posedge mclk);
    #1;
  endtask

  // keyword, comma separated hex, raw payload, return
  task automatic send_line(logic [31:0] kw, string prm, int raw_n, int raw_off, bit cr);
    @(posedge mclk);
    #1;
    for (int k = 3; k >= 0; k--) begin
      if (kw[8*k +: 8] != 8'h00) put(kw[8*k +: 8]);
    end
    for (int k = 0; k < prm.len(); k++) begin
      put(prm[k]);
    end
    // payload as raw bytes, not text
    for (int k = 0; k < raw_n; k++) begin
      put(img_byte(raw_off + k));
    end
    if (cr) put(CHAR_CR);
    rx.valid = 1'b0;
    rx.data = ~rx.data;
  endtask
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the update sequencer
module tb_top
  import sfu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TMO = 200;
  localparam int IMG = 16;
  localparam logic [31:0] IMG_ID = 32'h1a2b3c4d; // arbitrary image id
  logic mclk;
  logic rst;
  logic busy;
  logic reboot;
  sfu_byte_t rx;
  sfu_reply_t reply;
  sfu_mode_t mode;
  int n_errors = 0;
  int cmp_count = 0;
  int n_boot = 0;
  logic [19:0] rq[$];

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  sfu_sequencer #(.TIMEOUT_CYC(TMO)) i_sfu_sequencer (
    .mclk(mclk), .rst(rst), .rx(rx), .busy(busy), .reply(reply), .mode(mode), .reboot(reboot)
  );
  sfu_host_model i_sfu_host_model (.rx(rx), .mclk(mclk));

  // reply capture on the settled half cycle
  always @(negedge mclk) begin
    if (reply.valid === 1'b1) rq.push_back({reply.code, reply.value});
    if (reboot === 1'b1) n_boot++;
  end

  task automatic chk(string what, logic [19:0] seen, logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rep(logic [31:0] kw, string prm, int rn = 0, int ro = 0);
    i_sfu_host_model.send_line(kw, prm, rn, ro, 1'b1);
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic pop(sfu_code_t c, logic [15:0] v = 16'h0000);
    logic [19:0] s;
    s = 'x;
    if (rq.size() > 0) s = rq.pop_front();
    chk("reply", s, {c, v});
  endtask

  task automatic none();
    chk("extra replies", 20'(rq.size()), 20'h00000);
  endtask

  function automatic logic [15:0] crc(int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {i_sfu_host_model.img_byte(i), 8'h00};
      repeat (8) c = c[15] ? ((c << 1) ^ CHECK_POLY) : (c << 1);
    end
    return c;
  endfunction

  task automatic frag(int n, int off);
    rep(KW_FRAGMENT, $sformatf(",%04h,", n[15:0]), n, off);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    rq.delete();
    n_boot = 0;
    chk("mode after reset", 20'(mode), 20'(MODE_CMD));
  endtask

  task automatic request(logic [15:0] cv);
    rep(KW_REQUEST, $sformatf(",%0h,01,%h,%0h", IMG, IMG_ID, cv));
    pop(REP_ECHO, MAX_FRAG_LEN);
  endtask

  task automatic t_enter();
    rep(KW_REQUEST, ",10,01,1,0");
    pop(REP_ERR);
    i_sfu_host_model.send_line(KW_ENTER, "", 0, 0, 1'b0);
    repeat (4) @(posedge mclk);
    none();
    rep(32'h0, "");
    pop(REP_END);
    pop(REP_PROMPT);
    chk("mode", 20'(mode), 20'(MODE_UPD));
    $display("test enter done");
  endtask

  task automatic t_start();
    rep(KW_START, "");
    pop(REP_ERR);
    request(crc(IMG));
    busy = 1'b1;
    rep(KW_START, "");
    pop(REP_BUSY);
    busy = 1'b0;
    rep(KW_START, "");
    pop(REP_ACK);
    $display("test start done");
  endtask

  task automatic t_full();
    frag(8, 0);
    pop(REP_ACK);
    rep(KW_REQUEST, ",10,01,1,0");
    pop(REP_ERR);
    rep(KW_COMPLETE, "");
    pop(REP_ERR);
    rep(KW_TERMINATE, "");
    pop(REP_ERR);
    frag(int'(MAX_FRAG_LEN) + 1, 8);
    pop(REP_ERR);
    frag(8, 8);
    pop(REP_ACK);
    rep(KW_COMPLETE, "");
    pop(REP_VALIDATING);
    pop(REP_VAL_OK);
    rep(KW_TERMINATE, "");
    pop(REP_REBOOT);
    chk("reboot pulses", 20'(n_boot), 20'h00001);
    rep(KW_ENTER, "");
    none();
    chk("mode", 20'(mode), 20'(MODE_DATA));
    $display("test full transfer done");
  endtask

  task automatic t_timeout();
    do_reset();
    t_enter();
    request(crc(IMG));
    rep(KW_START, "");
    pop(REP_ACK);
    frag(8, 0);
    pop(REP_ACK);
    repeat (TMO - 50) @(posedge mclk);
    #1;
    chk("mode", 20'(mode), 20'(MODE_UPD));
    repeat (100) @(posedge mclk);
    #1;
    chk("mode", 20'(mode), 20'(MODE_CMD));
    none();
    $display("test timeout done");
  endtask

  task automatic t_abort();
    do_reset();
    t_enter();
    request(crc(IMG) ^ 16'h0001);
    rep(KW_TERMINATE, "");
    pop(REP_END);
    request(crc(IMG) ^ 16'h0001);
    rep(KW_START, "");
    pop(REP_ACK);
    rep(KW_COMPLETE, "");
    pop(REP_ERR);
    frag(IMG, 0);
    pop(REP_ACK);
    rep(KW_COMPLETE, "");
    pop(REP_VALIDATING);
    pop(REP_VAL_FAIL);
    rep(KW_TERMINATE, "");
    pop(REP_END);
    chk("mode", 20'(mode), 20'(MODE_UPD));
    chk("reboot pulses", 20'(n_boot), 20'h00000);
    $display("test abort done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    busy = 1'b0;
    do_reset();
    t_enter();
    t_start();
    t_full();
    t_timeout();
    t_abort();
    give_verdict();
  end
endmodule
